// ### hdl/ism_regmap.sv
// Serial-link register map with locality handling, data FIFO and hash strobes.
// Assumes the serial clock and data pins are external and asynchronous to i_sys_clk.
`default_nettype none

module ism_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_wr_valid,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_wr_ready,
  output logic o_rd_valid,
  output logic [WIDTH-1:0] o_rd_data,
  input wire logic i_rd_ready,
  output logic [15:0] o_free
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // The output slot counts toward the depth, so at most DEPTH words are held.
  assign o_wr_ready = ((cnt_q + (AW+1)'(o_rd_valid)) != (AW+1)'(DEPTH));
  assign push = i_wr_valid && o_wr_ready;
  assign pop = (cnt_q != '0) && (!o_rd_valid || i_rd_ready);
  assign o_free = 16'((AW+1)'(DEPTH) - cnt_q - (AW+1)'(o_rd_valid));

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_q[wptr_q] <= i_wr_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
    end else if (pop) begin
      o_rd_valid <= 1'b1;
      o_rd_data <= mem_q[rptr_q];
    end else if (i_rd_ready) begin
      o_rd_valid <= 1'b0;
    end
  end
endmodule : ism_fifo

module ism_regmap
  import ism_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter logic [15:0] VENDOR_CODE = 16'h0a5a, // Arbitrary value.
  parameter logic [15:0] DEVICE_CODE = 16'h0001, // Arbitrary value.
  parameter logic [7:0] REVISION_CODE = 8'h01 // Arbitrary value.
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_data,
  output logic o_cmd_hash,
  input wire logic i_cmd_ready,
  input wire logic i_rsp_valid,
  input wire logic [7:0] i_rsp_data,
  output logic o_rsp_ready,
  output logic o_hash_start,
  output logic o_hash_end,
  output logic o_trust_seq_active,
  output logic [7:0] o_locality,
  output logic [6:0] o_dev_addr
);
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  logic scl_rise, scl_fall, start_det, stop_det;
  ism_state_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] sub_q;
  logic rw_q, nack_q;
  logic [7:0] loc_q;
  logic [7:0] own_q [5];
  logic [31:0] ien_q, ists_q;
  logic [7:0] sts0_q, sts3_q, csen_q;
  logic [15:0] csum_q;
  logic trust_seq_q;
  logic [6:0] addr_new_q;
  logic addr_pend_q;
  logic wr_stb, rd_stb, fifo_wr_ok, ack_ok, own_ok, byte_ok;
  logic [7:0] rd_byte;
  logic [31:0] word;
  logic [2:0] wlen;
  logic [15:0] fifo_free;
  logic fifo_wr_ready;

  // Pins pass three flops; edge logic reads only the second and third stages.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {scl_s1, scl_s2, scl_s3} <= 3'b111;
      {sda_s1, sda_s2, sda_s3} <= 3'b111;
    end else begin
      {scl_s3, scl_s2, scl_s1} <= {scl_s2, scl_s1, i_scl};
      {sda_s3, sda_s2, sda_s1} <= {sda_s2, sda_s1, i_sda};
    end
  end

  assign scl_rise = scl_s2 && !scl_s3;
  assign scl_fall = !scl_s2 && scl_s3;
  assign start_det = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_det = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

  assign wr_stb = scl_fall && (st_q == ST_WRITE) && (cnt_q == BITS_PER_BYTE);
  assign rd_stb = scl_fall && (st_q == ST_READ) && (cnt_q == BITS_PER_BYTE);
  assign own_ok = (loc_q <= LOC_MAX);
  assign fifo_wr_ok = wr_stb && (sub_q == A_FIFO) && fifo_wr_ready;
  assign ack_ok = (sub_q != A_FIFO) || fifo_wr_ready;

  // Read data is decoded per byte address; unmapped bytes read 0xff.
  always_comb begin
    word = '0;
    wlen = 3'd0;
    case (sub_q & WORD_MASK)
      A_LOC: begin word = {24'h0, loc_q}; wlen = 3'd1; end
      A_OWN: begin word = {24'h0, own_ok ? own_q[loc_q[2:0]] : BYTE_NONE}; wlen = 3'd1; end
      A_IEN: begin word = ien_q; wlen = 3'd4; end
      A_ISTS: begin word = ists_q; wlen = 3'd4; end
      A_ICAP: begin word = ICAP_VAL; wlen = 3'd4; end
      A_STS: begin
        word = {sts3_q, fifo_free, sts0_q};
        word[STS_AVAIL_BIT] = i_rsp_valid;
        wlen = 3'd4;
      end
      A_FIFO: begin word = {24'h0, i_rsp_valid ? i_rsp_data : BYTE_NONE}; wlen = 3'd1; end
      A_LCAP: begin word = LCAP_VAL; wlen = 3'd4; end
      A_CSEN: begin word = {24'h0, csen_q}; wlen = 3'd1; end
      A_CSUM: begin word = {16'h0, csum_q}; wlen = 3'd2; end
      A_IDENT: begin word = {DEVICE_CODE, VENDOR_CODE}; wlen = 3'd4; end
      A_RID: begin word = {24'h0, REVISION_CODE}; wlen = 3'd1; end
      default: begin word = '0; wlen = 3'd0; end
    endcase
    byte_ok = ({1'b0, sub_q[1:0]} < wlen);
    rd_byte = byte_ok ? word[{sub_q[1:0], 3'b000} +: 8] : BYTE_NONE;
  end

  // Serial protocol engine.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      shift_q <= '0;
      sub_q <= '0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      o_sda_oe_n <= 1'b1;
      o_sda <= 1'b0;
    end else if (start_det) begin
      st_q <= ST_DEVADDR;
      cnt_q <= '0;
      o_sda_oe_n <= 1'b1;
    end else if (stop_det) begin
      st_q <= ST_IDLE;
      o_sda_oe_n <= 1'b1;
    end else if (scl_rise) begin
      case (st_q)
        ST_DEVADDR, ST_SUBADDR, ST_WRITE: begin
          shift_q <= {shift_q[6:0], sda_s2};
          cnt_q <= cnt_q + 4'd1;
        end
        ST_READ: cnt_q <= cnt_q + 4'd1;
        ST_ACK_RD: nack_q <= sda_s2;
        default: cnt_q <= cnt_q;
      endcase
    end else if (scl_fall) begin
      case (st_q)
        ST_DEVADDR: begin
          if (cnt_q == BITS_PER_BYTE) begin
            if (shift_q[7:1] == o_dev_addr) begin
              st_q <= ST_ACK_DEV;
              rw_q <= shift_q[0];
              o_sda_oe_n <= 1'b0;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_ACK_DEV: begin
          cnt_q <= '0;
          if (rw_q) begin
            st_q <= ST_READ;
            shift_q <= rd_byte;
            o_sda_oe_n <= rd_byte[7];
          end else begin
            st_q <= ST_SUBADDR;
            o_sda_oe_n <= 1'b1;
          end
        end
        ST_SUBADDR: begin
          if (cnt_q == BITS_PER_BYTE) begin
            sub_q <= shift_q;
            st_q <= ST_ACK_SUB;
            o_sda_oe_n <= 1'b0;
          end
        end
        ST_ACK_SUB, ST_ACK_WR: begin
          st_q <= ST_WRITE;
          cnt_q <= '0;
          o_sda_oe_n <= 1'b1;
        end
        ST_WRITE: begin
          if (cnt_q == BITS_PER_BYTE) begin
            st_q <= ack_ok ? ST_ACK_WR : ST_IDLE;
            o_sda_oe_n <= !ack_ok;
            if (sub_q != A_FIFO) begin
              sub_q <= sub_q + 8'd1;
            end
          end
        end
        ST_READ: begin
          if (cnt_q == BITS_PER_BYTE) begin
            st_q <= ST_ACK_RD;
            o_sda_oe_n <= 1'b1;
            if (sub_q != A_FIFO) begin
              sub_q <= sub_q + 8'd1;
            end
          end else begin
            o_sda_oe_n <= shift_q[3'(MSB_IDX - cnt_q)];
          end
        end
        ST_ACK_RD: begin
          cnt_q <= '0;
          if (nack_q) begin
            st_q <= ST_IDLE;
            o_sda_oe_n <= 1'b1;
          end else begin
            st_q <= ST_READ;
            shift_q <= rd_byte;
            o_sda_oe_n <= rd_byte[7];
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Locality selection and dynamic trust root sequence state.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      loc_q <= LOC_RST;
      trust_seq_q <= 1'b0;
      o_hash_start <= 1'b0;
      o_hash_end <= 1'b0;
    end else begin
      o_hash_start <= 1'b0;
      o_hash_end <= 1'b0;
      if (wr_stb && sub_q == A_LOC && !trust_seq_q) begin
        loc_q <= shift_q;
      end
      if (wr_stb && sub_q == A_HSTART && loc_q == LOC_HASH) begin
        trust_seq_q <= 1'b1;
        o_hash_start <= 1'b1;
      end else if (wr_stb && sub_q == A_HEND && loc_q == LOC_HASH) begin
        trust_seq_q <= 1'b0;
        o_hash_end <= 1'b1;
      end
    end
  end

  // Ownership copies, one per locality.
  for (genvar g = 0; g < 5; g++) begin : g_own
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        own_q[g] <= OWN_RST;
      end else if (wr_stb && sub_q == A_OWN && loc_q == 8'(g)) begin
        own_q[g] <= shift_q;
      end
    end
  end
  // Shared registers: interrupt enable, status, general status, checksum.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ien_q <= '0;
      ists_q <= '0;
      sts0_q <= '0;
      sts3_q <= '0;
      csen_q <= '0;
      csum_q <= '0;
    end else begin
      if (wr_stb && (sub_q & WORD_MASK) == A_IEN) begin
        ien_q[{sub_q[1:0], 3'b000} +: 8] <= shift_q & IEN_MASK[{sub_q[1:0], 3'b000} +: 8];
      end
      ists_q[ISTS_DATA_BIT] <= i_rsp_valid ||
        (ists_q[ISTS_DATA_BIT] && !(wr_stb && sub_q == A_ISTS && shift_q[ISTS_DATA_BIT]));
      ists_q[ISTS_LOC_BIT] <= (wr_stb && sub_q == A_LOC && !trust_seq_q && shift_q != loc_q) ||
        (ists_q[ISTS_LOC_BIT] && !(wr_stb && sub_q == A_ISTS && shift_q[ISTS_LOC_BIT]));
      if (wr_stb && sub_q == A_STS) begin
        sts0_q <= shift_q;
      end
      if (wr_stb && sub_q == A_STS + 8'd3) begin
        sts3_q <= shift_q & STS3_MASK;
      end
      if (wr_stb && sub_q == A_CSEN) begin
        csen_q <= shift_q;
        csum_q <= '0;
      end else if (csen_q[0] && (fifo_wr_ok || (rd_stb && sub_q == A_FIFO))) begin
        csum_q <= csum_q + {8'h00, fifo_wr_ok ? shift_q : rd_byte};
      end
    end
  end
  // Device address change takes effect at the next stop condition.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dev_addr <= DEV_ADDR_RST;
      addr_new_q <= DEV_ADDR_RST;
      addr_pend_q <= 1'b0;
      o_rsp_ready <= 1'b0;
    end else begin
      o_rsp_ready <= rd_stb && sub_q == A_FIFO && i_rsp_valid;
      if (wr_stb && sub_q == A_ADDRCHG) begin
        addr_new_q <= shift_q[6:0];
        addr_pend_q <= 1'b1;
      end else if (stop_det && addr_pend_q) begin
        o_dev_addr <= addr_new_q;
        addr_pend_q <= 1'b0;
      end
    end
  end

  assign o_locality = loc_q;
  assign o_trust_seq_active = trust_seq_q;
  ism_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_wr_valid(wr_stb && sub_q == A_FIFO),
    .i_wr_data({loc_q == LOC_HASH, shift_q}),
    .o_wr_ready(fifo_wr_ready),
    .o_rd_valid(o_cmd_valid),
    .o_rd_data({o_cmd_hash, o_cmd_data}),
    .i_rd_ready(i_cmd_ready),
    .o_free(fifo_free)
  );
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_dev_match;
    scl_fall && st_q == ST_DEVADDR && cnt_q == BITS_PER_BYTE && shift_q[7:1] == o_dev_addr;
  endsequence
  sequence s_loc_write;
    wr_stb && sub_q == A_LOC && !trust_seq_q;
  endsequence
  chk_dev_ack: assert property (s_dev_match |=> !o_sda_oe_n && st_q == ST_ACK_DEV)
    else $error("Matching device address not acknowledged.");
  chk_loc_write: assert property (s_loc_write |=> loc_q == $past(shift_q))
    else $error("Locality selection write lost.");
  chk_loc_frozen: assert property (trust_seq_q |=> $stable(loc_q))
    else $error("Locality changed during hash sequence.");
  chk_hstart_loc: assert property (o_hash_start |-> $past(loc_q) == LOC_HASH)
    else $error("Hash start outside locality 4.");
  chk_hend_loc: assert property (o_hash_end |-> $past(loc_q) == LOC_HASH && !trust_seq_q)
    else $error("Hash end outside locality 4.");
  chk_own_copy: assert property (wr_stb && sub_q == A_OWN && loc_q == 8'h02 |=>
    own_q[2] == $past(shift_q) && $stable(own_q[0]) && $stable(own_q[4]))
    else $error("Ownership copy mismatch.");
  chk_byte_queued: assert property (fifo_wr_ok |=>
    ##[0:2] (fifo_free != 16'(FIFO_DEPTH) || o_cmd_valid))
    else $error("Data port byte not queued.");
  chk_unmapped_ff: assert property ((sub_q & WORD_MASK) == A_HEND |-> rd_byte == BYTE_NONE)
    else $error("Unmapped read not 0xff.");
  chk_ro_discard: assert property (wr_stb && (sub_q == A_ICAP || sub_q == 8'h0c) |=>
    $stable(ien_q) && $stable(loc_q) && $stable(sts0_q))
    else $error("Read-only write changed state.");
  chk_hash_flag: assert property (fifo_wr_ok && !o_cmd_valid && fifo_free == 16'(FIFO_DEPTH) |=>
    ##1 (o_cmd_valid && o_cmd_hash == $past(loc_q == LOC_HASH, 2)))
    else $error("Hash flag wrong on queued byte.");
endmodule : ism_regmap
`default_nettype wire

// ### hdl/ism_pkg.sv
// Constants, register offsets and state codes for the serial security register map.
// Assumes a single system clock and a two-wire serial link sampled on that clock.
// What this block does
// - Every register is a byte sub-address below one shared device bus address.
// - Ownership register has one independent copy per locality, chosen by selection.
// - All other registers are single shared instances for every locality.
// - Locality selection is a one-byte read-write register at sub-address 0x00.
// - Ownership is a one-byte read-write register at sub-address 0x04.
// - Interrupt enable is four bytes, read-write, at sub-address 0x08.
// - Interrupt status is four bytes, readable and writable, at sub-address 0x10.
// - Interrupt capability is four bytes, read-only, at sub-address 0x14.
// - General status is four bytes, read-write, at 0x18 through 0x1b.
// - Hash end strobe at 0x20 is write-only and acts only in locality 4.
// - Hash start strobe at 0x28 is write-only and acts only in locality 4.
// - Data port at 0x24 carries command and response bytes, limited by allowance.
// - In locality 4, data port writes are hash data instead of command data.
// - Two-byte write-only register at 0x38 changes the device bus address.
// - Checksum enable is a one-byte read-write register at 0x40.
// - Checksum result is two bytes, read-only, at 0x44.
// - Identification at 0x48 holds vendor code 15:0 and device code 31:16.
// - Locality selection holds until rewritten, reads back, and resets to 0x00.
// - Locality selection writes are ignored between hash start and hash end.
// - Reads of unassigned addresses or beyond a register end return 0xff.
// - Multi-byte values go least significant byte first, lowest address first.
`default_nettype none
package ism_pkg;
  localparam logic [7:0] A_LOC = 8'h00;
  localparam logic [7:0] A_OWN = 8'h04;
  localparam logic [7:0] A_IEN = 8'h08;
  localparam logic [7:0] A_ISTS = 8'h10;
  localparam logic [7:0] A_ICAP = 8'h14;
  localparam logic [7:0] A_STS = 8'h18;
  localparam logic [7:0] A_HEND = 8'h20;
  localparam logic [7:0] A_FIFO = 8'h24;
  localparam logic [7:0] A_HSTART = 8'h28;
  localparam logic [7:0] A_LCAP = 8'h30;
  localparam logic [7:0] A_ADDRCHG = 8'h38;
  localparam logic [7:0] A_CSEN = 8'h40;
  localparam logic [7:0] A_CSUM = 8'h44;
  localparam logic [7:0] A_IDENT = 8'h48;
  localparam logic [7:0] A_RID = 8'h4c;
  localparam logic [7:0] WORD_MASK = 8'hfc;
  localparam logic [7:0] LOC_RST = 8'h00;
  localparam logic [7:0] LOC_HASH = 8'h04;
  localparam logic [7:0] LOC_MAX = 8'h04;
  localparam logic [7:0] BYTE_NONE = 8'hff;
  localparam logic [7:0] OWN_RST = 8'h00;
  localparam logic [31:0] IEN_MASK = 32'h8000_0087;
  localparam logic [31:0] ICAP_VAL = 32'h0000_0005;
  localparam logic [31:0] LCAP_VAL = 32'h0000_0000;
  localparam logic [7:0] STS3_MASK = 8'h01;
  localparam int ISTS_DATA_BIT = 0;
  localparam int ISTS_LOC_BIT = 2;
  localparam int STS_AVAIL_BIT = 4;
  localparam logic [6:0] DEV_ADDR_RST = 7'h2e;
  localparam logic [3:0] BITS_PER_BYTE = 4'd8;
  localparam logic [3:0] MSB_IDX = 4'd7;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_DEVADDR = 4'b0001,
    ST_ACK_DEV = 4'b0010,
    ST_SUBADDR = 4'b0011,
    ST_ACK_SUB = 4'b0100,
    ST_WRITE = 4'b0101,
    ST_ACK_WR = 4'b0110,
    ST_READ = 4'b0111,
    ST_ACK_RD = 4'b1000
  } ism_state_t;
endpackage : ism_pkg
`default_nettype wire

// ### sim/ism_host_model.sv
// Bus master model that drives the two-wire link of the register map.
// Assumes a pull-up on the data line and times its bits off the bench clock.
`default_nettype none
module ism_host_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe_n,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic nack;
  initial begin
    o_scl = 1'b1;
    o_sda_oe_n = 1'b1;
    o_rd_valid = 1'b0;
    o_rd_data = 8'h00;
    nack = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask : tick
  // One bit lasts 400 ns; data only moves while the clock is low.
  task automatic bit_xfer(input logic b, output logic s);
    tick(2);
    o_sda_oe_n = b;
    tick(2);
    o_scl = 1'b1;
    tick(2);
    s = i_sda;
    tick(2);
    o_scl = 1'b0;
  endtask : bit_xfer
  // Start when stop is low, stop otherwise; the clock stands high after a stop.
  task automatic cond(input logic stop);
    tick(2);
    o_sda_oe_n = ~stop;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    o_sda_oe_n = stop;
    tick(4);
    if (!stop) o_scl = 1'b0;
  endtask : cond
  task automatic wbyte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
    bit_xfer(1'b1, s);
    nack = s;
  endtask : wbyte
  task automatic rbyte(input logic last);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      d[i] = s;
    end
    bit_xfer(last, s);
    o_rd_data = d;
    o_rd_valid = 1'b1;
    tick(1);
    o_rd_valid = 1'b0;
  endtask : rbyte
  task automatic wr(input logic [6:0] dev, input logic [7:0] sub, input logic [7:0] d[$]);
    cond(1'b0);
    wbyte({dev, 1'b0});
    if (!nack) wbyte(sub);
    foreach (d[i]) if (!nack) wbyte(d[i]);
    cond(1'b1);
  endtask : wr
  task automatic rd(input logic [6:0] dev, input logic [7:0] sub, input int n);
    cond(1'b0);
    wbyte({dev, 1'b0});
    wbyte(sub);
    cond(1'b0);
    wbyte({dev, 1'b1});
    for (int i = 0; i < n; i++) rbyte(i == n - 1);
    cond(1'b1);
  endtask : rd
endmodule : ism_host_model
`default_nettype wire

// ### sim/ism_regmap_tb.sv
// Self-checking bench for the register map, driven through the host model.
// Assumes the data line is pulled up and both parties only pull it low.
`default_nettype none
module ism_regmap_tb import ism_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DEPTH = 8;
  localparam int LIMIT = 60000;
  localparam logic [15:0] VC = 16'h3c21; // Arbitrary value.
  localparam logic [15:0] DC = 16'h0007; // Arbitrary value.
  localparam logic [7:0] RC = 8'h02; // Arbitrary value.
  logic sys_clk, rst_n, scl, host_oe_n, sda, dut_oe_n, drain;
  logic cmd_valid, cmd_hash, cmd_ready, rsp_valid, rsp_ready, hs, he, tseq, host_rd_valid, sda_drv;
  logic [7:0] cmd_data, rsp_data, locality, host_rd_data, b;
  logic [6:0] dev_addr, dev;
  logic [31:0] seed, w;
  logic [15:0] sum;
  int errors, n_compared, n_hs, n_he, n_rsp, cyc;
  logic [7:0] rdq[$];
  logic [8:0] cmdq[$];
  logic [7:0] resv[9] = '{8'h01, 8'h0c, 8'h1c, 8'h2a, 8'h34, 8'h3a, 8'h46, 8'h4d, 8'hff};
  assign sda = host_oe_n & dut_oe_n;
  ism_regmap #(.FIFO_DEPTH(DEPTH), .VENDOR_CODE(VC), .DEVICE_CODE(DC), .REVISION_CODE(RC)) dut (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda(sda_drv),
    .o_sda_oe_n(dut_oe_n), .o_cmd_valid(cmd_valid), .o_cmd_data(cmd_data),
    .o_cmd_hash(cmd_hash), .i_cmd_ready(cmd_ready), .i_rsp_valid(rsp_valid),
    .i_rsp_data(rsp_data), .o_rsp_ready(rsp_ready), .o_hash_start(hs), .o_hash_end(he),
    .o_trust_seq_active(tseq), .o_locality(locality), .o_dev_addr(dev_addr));
  ism_host_model host (.i_clk(sys_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe_n(host_oe_n),
    .o_rd_valid(host_rd_valid), .o_rd_data(host_rd_data));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] sub, input logic [7:0] d[$]);
    host.wr(dev, sub, d);
  endtask : wr
  task automatic rd(input logic [7:0] sub, input logic [7:0] e[$]);
    foreach (e[i]) rdq.push_back(e[i]);
    host.rd(dev, sub, e.size());
  endtask : rd
  task automatic send(input int n, input logic h);
    logic [7:0] d[$];
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      d.push_back(seed[7:0]);
      cmdq.push_back({h, seed[7:0]});
      sum += 16'(seed[7:0]);
    end
    host.wr(dev, A_FIFO, d);
  endtask : send
  task automatic drain_wait;
    drain = 1'b1;
    for (int i = 0; i < 400 && cmdq.size() != 0; i++) @(posedge sys_clk);
    #2;
    check(32'(cmdq.size()), 32'h0);
  endtask : drain_wait
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      complete_run();
    end
  end
  always @(posedge sys_clk) begin
    if (host_rd_valid === 1'b1) begin
      if (rdq.size() == 0) check(32'h0, 32'h1);
      else check(32'(host_rd_data), 32'(rdq.pop_front()));
    end
    if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
      check(32'({cmd_hash, cmd_data}), 32'(cmdq.pop_front()));
    end
    if (hs === 1'b1) n_hs++;
    if (he === 1'b1) n_he++;
    if (rsp_ready === 1'b1) begin
      n_rsp++;
      rsp_valid <= #2 1'b0;
    end
  end
  always @(posedge sys_clk) begin
    #2;
    seed = lfsr(seed);
    cmd_ready = drain & seed[3];
  end
  initial begin
    seed = 32'h2e738de0;
    rst_n = 1'b0;
    cmd_ready = 1'b0;
    rsp_valid = 1'b0;
    rsp_data = 8'h00;
    drain = 1'b0;
    sum = 16'h0000;
    dev = DEV_ADDR_RST;
    repeat (16) @(posedge sys_clk);
    #2;
    rst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    #2;
    check(32'(locality), 32'(LOC_RST));
    check(32'(dev_addr), 32'(DEV_ADDR_RST));
    rd(A_LOC, {8'h00});
    rd(A_STS + 8'h01, {8'(DEPTH), 8'h00});
    $display("test reset_values done");
    wr(A_LOC, {8'h02});
    wr(A_OWN, {8'h02});
    for (int l = 0; l < 6; l++) begin
      wr(A_LOC, {8'(l)});
      check(32'(locality), 32'(l));
      rd(A_LOC, {8'(l)});
      rd(A_OWN, {(l == 2) ? 8'h02 : (l > 4) ? 8'hff : 8'h00});
    end
    $display("test localities done");
    wr(A_LOC, {8'h00});
    seed = lfsr(seed);
    w = seed & IEN_MASK;
    wr(A_IEN, {seed[7:0], seed[15:8], seed[23:16], seed[31:24]});
    wr(A_LOC, {8'h03});
    rd(A_IEN, {w[7:0], w[15:8], w[23:16], w[31:24]});
    wr(A_ICAP, {8'hff, 8'hff, 8'hff, 8'hff});
    rd(A_ICAP, {ICAP_VAL[7:0], ICAP_VAL[15:8], ICAP_VAL[23:16], ICAP_VAL[31:24]});
    wr(A_ISTS, {8'hff, 8'hff, 8'hff, 8'hff});
    rd(A_ISTS, {8'h00, 8'h00, 8'h00, 8'h00});
    rd(A_IDENT, {VC[7:0], VC[15:8], DC[7:0], DC[15:8], RC});
    foreach (resv[i]) begin
      wr(resv[i], {8'h5a});
      rd(resv[i], {8'hff});
    end
    rd(A_CSEN, {8'h00, 8'hff});
    $display("test shared_registers done");
    wr(A_LOC, {8'h00});
    send(DEPTH, 1'b0);
    check(32'(host.nack), 32'h0);
    rd(A_STS + 8'h01, {8'h00, 8'h00});
    host.wr(dev, A_FIFO, {8'ha5});
    check(32'(host.nack), 32'h1);
    drain_wait();
    rd(A_STS + 8'h01, {8'(DEPTH), 8'h00});
    $display("test fifo done");
    wr(A_CSEN, {8'h01});
    sum = 16'h0000;
    send(2, 1'b0);
    seed = lfsr(seed);
    b = seed[7:0];
    sum += 16'(b);
    rsp_data = b;
    rsp_valid = 1'b1;
    rd(A_FIFO, {b});
    check(32'(n_rsp), 32'h1);
    rd(A_CSUM, {sum[7:0], sum[15:8], 8'hff});
    rd(A_CSEN, {8'h01});
    drain_wait();
    $display("test checksum done");
    wr(A_HSTART, {8'h00});
    wr(A_HEND, {8'h00});
    check(32'(n_hs), 32'h0);
    check(32'(n_he), 32'h0);
    wr(A_LOC, {LOC_HASH});
    wr(A_OWN, {8'h02});
    wr(A_HSTART, {8'h00});
    check(32'(n_hs), 32'h1);
    check(32'(tseq), 32'h1);
    send(1, 1'b1);
    wr(A_LOC, {8'h01});
    check(32'(locality), 32'(LOC_HASH));
    wr(A_HEND, {8'h00});
    check(32'(n_he), 32'h1);
    check(32'(tseq), 32'h0);
    wr(A_LOC, {8'h00});
    check(32'(locality), 32'h0);
    drain_wait();
    $display("test hash done");
    wr(A_ADDRCHG, {8'h31, 8'h00});
    check(32'(dev_addr), 32'h31);
    host.wr(dev, A_LOC, {8'h02});
    check(32'(host.nack), 32'h1);
    dev = 7'h31;
    rd(A_LOC, {8'h00});
    $display("test address_change done");
    check(32'(rdq.size()), 32'h0);
    check(32'(sda_drv), 32'h0);
    complete_run();
  end
endmodule : ism_regmap_tb
`default_nettype wire
